//--- hw/codec_ctrl_pkg.sv
package codec_ctrl_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [15:0] CTRL_ADDR = 16'hFFC8;
   localparam logic [15:0] STATUS_ADDR = 16'hFFE8;
   localparam logic [15:0] RX_ADDR = 16'hFFE9;
   localparam logic [15:0] TX_ADDR = 16'hFFE9;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] CTRL_WMASK = 16'hFF0F;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int VOL_LSB = 0;
   localparam int RATE_LSB = 8;
   localparam int MUTE_BIT = 10;
   localparam int GAIN_LSB = 11;
   localparam int SRC_BIT = 13;
   localparam int EN_BIT = 14;
   localparam int IRQEN_BIT = 15;
   localparam int UNDER_BIT = 0;
   localparam int OVER_BIT = 1;
   localparam int EMPTY_BIT = 2;
   localparam int FULL_BIT = 3;
   // ------------------------------------------------------------
   // Encodings
   // ------------------------------------------------------------
   localparam logic [7:0] RATIO_125 = 8'h7D;
   localparam logic [7:0] RATIO_128 = 8'h80;
   localparam logic [7:0] RATIO_105 = 8'h69;
   localparam logic [7:0] RATIO_81 = 8'h51;
   localparam logic [7:0] GAIN_M6 = 8'hFA;
   localparam logic [7:0] GAIN_0 = 8'h00;
   localparam logic [7:0] GAIN_6 = 8'h06;
   localparam logic [7:0] GAIN_17 = 8'h11;
endpackage : codec_ctrl_pkg

//--- hw/codec_ctrl_status_interface.sv
`timescale 1ns/1ps
// Overview of operation
// - Gain field bits 12:11 selects -6, 0, 6 or 17 dB input gain.
// - Bit 13 routes first input when zero, second input when one.
// - Bit 14 clear powers the codec down; set wakes and enables it.
// - Bit 15 gates the codec interrupt request.
// - Control bits 4-7 read as zero; software writes zero.
// - Status register is eight bits and read-only; writes change nothing.
// - Underrun flag sets when a sample is due but none was written.
// - On underrun the previous transmit sample is resent.
// - Underrun clears on resets or status read then transmit write.
// - Overrun flag sets when new sample overwrites an unread one.
// - Overrun clears on resets or status read then receive read.
// - Empty flag sets on transfer to filter, clears on transmit write.
// - Empty flag forced set on power-down entry and all resets.
// - Full flag sets on receive load, clears on receive read.
// - Full flag cleared on power-down entry and all resets.
// - Status bits above 3 read as zero.
// - Status at FFE8 hex, control at FFC8 hex.
// - All control bits cleared by hardware and software reset.
// - Bit 10 low silences the speaker output.
// - Bits 9:8 pick ratio 125, 128, 105 or 81.
// - One shared interrupt signals receive ready and transmit room.
module codec_ctrl_status_interface
   import codec_ctrl_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic softRst,
   input wire logic stopRst,
   input wire logic [15:0] addr,
   input wire logic rdEn,
   input wire logic wrEn,
   input wire logic [15:0] wrData,
   output logic [15:0] rdData,
   input wire logic sampleStrobe,
   input wire logic [15:0] adcSample,
   output logic [15:0] dacSample,
   output logic [7:0] rateRatio,
   output logic [7:0] inputGainDb,
   output logic inputSourceSelect,
   output logic converterPowerDown,
   output logic speakerSilence_n,
   output logic [3:0] outputLevelSelect,
   output logic codecIrq
);
   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   logic [15:0] converterControlReg;
   logic [15:0] rxSampleReg;
   logic [15:0] txSampleReg;
   logic txUnderrunFlag;
   logic rxOverrunFlag;
   logic txEmptyFlag;
   logic rxFullFlag;
   logic underSeen;
   logic overSeen;
   logic [7:0] statusView;
   logic anyRst;
   logic ctrlWr;
   logic statusRd;
   logic rxRd;
   logic txWr;
   logic convEnable;
   logic powerDownEntry;
   logic strobeActive;

   function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
      hit = (a == b);
   endfunction : hit

   assign anyRst = softRst | stopRst;
   assign ctrlWr = wrEn & hit(addr, CTRL_ADDR);
   assign statusRd = rdEn & hit(addr, STATUS_ADDR);
   assign rxRd = rdEn & hit(addr, RX_ADDR);
   assign txWr = wrEn & hit(addr, TX_ADDR);
   assign convEnable = converterControlReg[EN_BIT];
   // Writes that clear the enable bit mark the entry into power-down
   assign powerDownEntry = ctrlWr & convEnable & ~wrData[EN_BIT];
   // Strobes are ignored while powered down; codec is not running
   assign strobeActive = sampleStrobe & convEnable;

   // ------------------------------------------------------------
   // Control register
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         converterControlReg <= CTRL_RESET;
      end else if (softRst) begin
         converterControlReg <= CTRL_RESET;
      end else if (ctrlWr) begin
         converterControlReg <= wrData & CTRL_WMASK;
      end
   end

   // ------------------------------------------------------------
   // Data registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rxSampleReg <= 16'h0000;
      end else if (strobeActive) begin
         rxSampleReg <= adcSample;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         txSampleReg <= 16'h0000;
      end else if (txWr) begin
         txSampleReg <= wrData;
      end
   end

   // Old word stays in place on underrun, so it is simply resent
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dacSample <= 16'h0000;
      end else if (strobeActive) begin
         dacSample <= txSampleReg;
      end
   end

   // ------------------------------------------------------------
   // Status flags
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         txEmptyFlag <= 1'b1;
      end else if (anyRst | powerDownEntry) begin
         txEmptyFlag <= 1'b1;
      end else if (strobeActive) begin
         txEmptyFlag <= 1'b1;
      end else if (txWr) begin
         txEmptyFlag <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rxFullFlag <= 1'b0;
      end else if (anyRst | powerDownEntry) begin
         rxFullFlag <= 1'b0;
      end else if (strobeActive) begin
         rxFullFlag <= 1'b1;
      end else if (rxRd) begin
         rxFullFlag <= 1'b0;
      end
   end

   // Underrun: due sample while transmit still empty
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         txUnderrunFlag <= 1'b0;
         underSeen <= 1'b0;
      end else if (anyRst) begin
         txUnderrunFlag <= 1'b0;
         underSeen <= 1'b0;
      end else begin
         if (strobeActive & txEmptyFlag) begin
            txUnderrunFlag <= 1'b1;
         end else if (txWr & underSeen) begin
            txUnderrunFlag <= 1'b0;
         end
         if (statusRd & txUnderrunFlag) begin
            underSeen <= 1'b1;
         end else if (txWr) begin
            underSeen <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rxOverrunFlag <= 1'b0;
         overSeen <= 1'b0;
      end else if (anyRst) begin
         rxOverrunFlag <= 1'b0;
         overSeen <= 1'b0;
      end else begin
         if (strobeActive & rxFullFlag & ~rxRd) begin
            rxOverrunFlag <= 1'b1;
         end else if (rxRd & overSeen) begin
            rxOverrunFlag <= 1'b0;
         end
         if (statusRd & rxOverrunFlag) begin
            overSeen <= 1'b1;
         end else if (rxRd) begin
            overSeen <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   always_comb begin
      statusView = 8'h00;
      statusView[UNDER_BIT] = txUnderrunFlag;
      statusView[OVER_BIT] = rxOverrunFlag;
      statusView[EMPTY_BIT] = txEmptyFlag;
      statusView[FULL_BIT] = rxFullFlag;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdData <= 16'h0000;
      end else if (rdEn) begin
         if (hit(addr, CTRL_ADDR)) begin
            rdData <= converterControlReg;
         end else if (hit(addr, STATUS_ADDR)) begin
            rdData <= {8'h00, statusView};
         end else if (hit(addr, RX_ADDR)) begin
            rdData <= rxSampleReg;
         end else begin
            rdData <= 16'h0000;
         end
      end
   end

   // ------------------------------------------------------------
   // Analog controls
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         inputGainDb <= GAIN_M6;
         rateRatio <= RATIO_125;
      end else begin
         case (converterControlReg[GAIN_LSB +: 2])
            2'b00: inputGainDb <= GAIN_M6;
            2'b01: inputGainDb <= GAIN_0;
            2'b10: inputGainDb <= GAIN_6;
            default: inputGainDb <= GAIN_17;
         endcase
         case (converterControlReg[RATE_LSB +: 2])
            2'b00: rateRatio <= RATIO_125;
            2'b01: rateRatio <= RATIO_128;
            2'b10: rateRatio <= RATIO_105;
            default: rateRatio <= RATIO_81;
         endcase
      end
   end

   assign inputSourceSelect = converterControlReg[SRC_BIT];
   assign converterPowerDown = ~convEnable;
   assign speakerSilence_n = converterControlReg[MUTE_BIT];
   assign outputLevelSelect = converterControlReg[VOL_LSB +: 4];
   // Shared vector for both directions
   assign codecIrq = converterControlReg[IRQEN_BIT] &
                     (rxFullFlag | txEmptyFlag);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_irq;
      @(posedge mclk) disable iff (rst)
      codecIrq == (converterControlReg[IRQEN_BIT] &
                   (rxFullFlag | txEmptyFlag));
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch");

   property p_full_set;
      @(posedge mclk) disable iff (rst)
      strobeActive & ~anyRst & ~powerDownEntry |=> rxFullFlag;
   endproperty
   a_full_set: assert property (p_full_set) else $error("full");

   property p_empty_wr;
      @(posedge mclk) disable iff (rst)
      txWr & ~strobeActive & ~anyRst & ~powerDownEntry |=> !txEmptyFlag;
   endproperty
   a_empty_wr: assert property (p_empty_wr) else $error("empty");

   property p_under;
      @(posedge mclk) disable iff (rst)
      strobeActive & txEmptyFlag & ~anyRst |=> txUnderrunFlag;
   endproperty
   a_under: assert property (p_under) else $error("underrun");

   property p_resend;
      @(posedge mclk) disable iff (rst)
      strobeActive |=> dacSample == $past(txSampleReg);
   endproperty
   a_resend: assert property (p_resend) else $error("resend");

   property p_over;
      @(posedge mclk) disable iff (rst)
      strobeActive & rxFullFlag & ~rxRd & ~anyRst |=> rxOverrunFlag;
   endproperty
   a_over: assert property (p_over) else $error("overrun");

   property p_pd;
      @(posedge mclk) disable iff (rst)
      powerDownEntry & ~anyRst |=> txEmptyFlag & !rxFullFlag;
   endproperty
   a_pd: assert property (p_pd) else $error("powerdown");

   property p_soft;
      @(posedge mclk) disable iff (rst)
      softRst |=> converterControlReg == CTRL_RESET && !txUnderrunFlag;
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset");

   property p_rsvd;
      @(posedge mclk) disable iff (rst)
      converterControlReg[7:4] == 4'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved");

   // Same-cycle underrun event wins over the clear
   property p_under_clr;
      @(posedge mclk) disable iff (rst)
      txWr & underSeen & ~(strobeActive & txEmptyFlag) & ~anyRst
         |=> !txUnderrunFlag;
   endproperty
   a_under_clr: assert property (p_under_clr) else $error("u clear");

   property p_over_clr;
      @(posedge mclk) disable iff (rst)
      rxRd & overSeen & ~anyRst |=> !rxOverrunFlag;
   endproperty
   a_over_clr: assert property (p_over_clr) else $error("o clear");

   property p_pd_keep;
      @(posedge mclk) disable iff (rst)
      powerDownEntry & ~strobeActive & ~anyRst
         |=> txUnderrunFlag == $past(txUnderrunFlag);
   endproperty
   a_pd_keep: assert property (p_pd_keep) else $error("pd under");

   property p_stop;
      @(posedge mclk) disable iff (rst)
      stopRst |=> txEmptyFlag && !rxFullFlag &&
         !txUnderrunFlag && !rxOverrunFlag;
   endproperty
   a_stop: assert property (p_stop) else $error("stop");

   property p_stat_wr;
      @(posedge mclk) disable iff (rst)
      wrEn & (addr == STATUS_ADDR) & ~strobeActive & ~anyRst
         |=> $stable(statusView);
   endproperty
   a_stat_wr: assert property (p_stat_wr) else $error("status wr");

   property p_full_rd;
      @(posedge mclk) disable iff (rst)
      rxRd & ~strobeActive |=> !rxFullFlag;
   endproperty
   a_full_rd: assert property (p_full_rd) else $error("full rd");

   c_pd: cover property (@(posedge mclk) disable iff (rst) powerDownEntry);
   c_resend: cover property (@(posedge mclk) disable iff (rst)
      strobeActive & txEmptyFlag);

   c_under: cover property (@(posedge mclk) disable iff (rst)
      txUnderrunFlag ##1 statusRd ##[1:20] txWr);
   c_over: cover property (@(posedge mclk) disable iff (rst)
      rxOverrunFlag ##1 statusRd ##[1:20] rxRd);
   c_irq: cover property (@(posedge mclk) disable iff (rst) codecIrq);
endmodule : codec_ctrl_status_interface

//--- verif/core_bus_model.sv
`timescale 1ns/1ps
module core_bus_model (
   input wire logic mclk,
   output logic [15:0] addr,
   output logic rdEn,
   output logic wrEn,
   output logic [15:0] wrData
);
   // ------------------------------------------------------------
   // Bus cycles
   // ------------------------------------------------------------
   initial begin
      addr = 16'h0000;
      rdEn = 1'b0;
      wrEn = 1'b0;
      wrData = 16'h0000;
   end
   // One rising edge per strobe; idle bus shows the inverse, not stale
   task automatic access(input logic [15:0] a, input logic w,
      input logic [15:0] d);
      @(negedge mclk);
      addr = a;
      wrData = d;
      rdEn = ~w;
      wrEn = w;
      @(negedge mclk);
      rdEn = 1'b0;
      wrEn = 1'b0;
      addr = ~a;
      wrData = ~d;
   endtask : access
endmodule : core_bus_model

//--- verif/testbench.sv
`timescale 1ns/1ps
module testbench;
   import codec_ctrl_pkg::*;
   logic mclk, rst, softRst, stopRst, sampleStrobe, rdEn, wrEn, rdPend;
   logic [15:0] addr, wrData, rdData, adcSample, dacSample, v, a, b, s;
   logic [7:0] rateRatio, inputGainDb;
   logic inputSourceSelect, converterPowerDown, speakerSilence_n, codecIrq;
   logic [3:0] outputLevelSelect;
   logic [15:0] expQ[$];
   logic [7:0] gainTab[4] = '{GAIN_M6, GAIN_0, GAIN_6, GAIN_17};
   logic [7:0] rateTab[4] = '{RATIO_125, RATIO_128, RATIO_105, RATIO_81};
   int errorCnt = 0;
   int checkCount = 0;
   int seed = 32'h039a_f82f;
   // ------------------------------------------------------------
   // Instances
   // ------------------------------------------------------------
   core_bus_model u_core (.mclk(mclk), .addr(addr), .rdEn(rdEn),
      .wrEn(wrEn), .wrData(wrData));
   codec_ctrl_status_interface u_dut (.mclk(mclk), .rst(rst),
      .softRst(softRst), .stopRst(stopRst), .addr(addr), .rdEn(rdEn),
      .wrEn(wrEn), .wrData(wrData), .rdData(rdData),
      .sampleStrobe(sampleStrobe), .adcSample(adcSample),
      .dacSample(dacSample), .rateRatio(rateRatio),
      .inputGainDb(inputGainDb), .inputSourceSelect(inputSourceSelect),
      .converterPowerDown(converterPowerDown),
      .speakerSilence_n(speakerSilence_n),
      .outputLevelSelect(outputLevelSelect), .codecIrq(codecIrq));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic conclude();
      if (errorCnt == 0 && checkCount > 0 && expQ.size() == 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checkCount++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         errorCnt++;
      end
   endtask : chk
   task automatic wr(input logic [15:0] ad, input logic [15:0] d);
      u_core.access(ad, 1'b1, d);
   endtask : wr
   // Expected read data is noted before the bus cycle starts
   task automatic rd(input logic [15:0] ad, input logic [15:0] e);
      expQ.push_back(e);
      u_core.access(ad, 1'b0, 16'h0000);
   endtask : rd
   task automatic strobe(input logic [15:0] d);
      @(negedge mclk);
      sampleStrobe = 1'b1;
      adcSample = d;
      @(negedge mclk);
      sampleStrobe = 1'b0;
      adcSample = ~d;
   endtask : strobe
   task automatic pulse(input logic stop);
      @(negedge mclk);
      if (stop) stopRst = 1'b1; else softRst = 1'b1;
      @(negedge mclk);
      stopRst = 1'b0;
      softRst = 1'b0;
   endtask : pulse
   // ------------------------------------------------------------
   // Read monitor: half a cycle after the taken strobe
   // ------------------------------------------------------------
   always @(posedge mclk) rdPend <= rdEn;
   always @(negedge mclk) begin
      if (rdPend === 1'b1) begin
         if (expQ.size() == 0) begin
            $display("MISMATCH t=%0t got=%h exp=none", $time, rdData);
            errorCnt++;
         end else begin
            chk(rdData, expQ.pop_front());
         end
      end
   end
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      errorCnt++;
      conclude();
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rst = 1'b1;
      softRst = 1'b0;
      stopRst = 1'b0;
      sampleStrobe = 1'b0;
      adcSample = 16'h0000;
      repeat (10) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      rd(CTRL_ADDR, CTRL_RESET);
      rd(STATUS_ADDR, 16'h0004);
      for (int i = 0; i < 16; i++) begin
         v = 16'($random(seed));
         v[15:14] = 2'b00;
         v[12:11] = i[1:0];
         v[9:8] = i[3:2];
         wr(CTRL_ADDR, v);
         @(negedge mclk);
         rd(CTRL_ADDR, v & CTRL_WMASK);
         chk(16'(inputGainDb), 16'(gainTab[i[1:0]]));
         chk(16'(rateRatio), 16'(rateTab[i[3:2]]));
         chk(16'(inputSourceSelect), 16'(v[13]));
         chk(16'(speakerSilence_n), 16'(v[10]));
         chk(16'(outputLevelSelect), 16'(v[3:0]));
         chk(16'(converterPowerDown), 16'h0001);
      end
      a = 16'($random(seed));
      b = 16'($random(seed));
      wr(CTRL_ADDR, 16'hc400);
      chk(16'(codecIrq), 16'h0001);
      chk(16'(converterPowerDown), 16'h0000);
      wr(TX_ADDR, a);
      chk(16'(codecIrq), 16'h0000);
      strobe(16'($random(seed)));
      chk(dacSample, a);
      rd(STATUS_ADDR, 16'h000c);
      s = 16'($random(seed));
      strobe(s);
      chk(dacSample, a);
      rd(STATUS_ADDR, 16'h000f);
      rd(RX_ADDR, s);
      rd(STATUS_ADDR, 16'h0005);
      wr(TX_ADDR, b);
      rd(STATUS_ADDR, 16'h0000);
      wr(STATUS_ADDR, 16'h00ff);
      rd(STATUS_ADDR, 16'h0000);
      rd(16'h1234, 16'h0000);
      strobe(16'($random(seed)));
      chk(dacSample, b);
      chk(16'(codecIrq), 16'h0001);
      wr(CTRL_ADDR, 16'h4400);
      chk(16'(codecIrq), 16'h0000);
      s = 16'($random(seed));
      strobe(s);
      rd(STATUS_ADDR, 16'h000f);
      rd(RX_ADDR, s);
      rd(STATUS_ADDR, 16'h0005);
      strobe(16'($random(seed)));
      rd(STATUS_ADDR, 16'h000d);
      wr(TX_ADDR, a);
      rd(STATUS_ADDR, 16'h0008);
      strobe(16'($random(seed)));
      strobe(16'($random(seed)));
      // Write without a status read first: underrun must stay set
      wr(TX_ADDR, b);
      wr(CTRL_ADDR, 16'h0400);
      rd(STATUS_ADDR, 16'h0007);
      strobe(16'($random(seed)));
      rd(STATUS_ADDR, 16'h0007);
      chk(dacSample, a);
      pulse(1'b1);
      rd(STATUS_ADDR, 16'h0004);
      rd(CTRL_ADDR, 16'h0400);
      pulse(1'b0);
      rd(CTRL_ADDR, CTRL_RESET);
      repeat (3) @(negedge mclk);
      conclude();
   end
endmodule : testbench
